/* hw/prr_pkg.sv */
// shared constants and types for the pmbus report responder
package prr_pkg;
  // command codes
  localparam logic [7:0] CMD_UV_WARN   = 8'h43;
  localparam logic [7:0] CMD_OC_LIM    = 8'h46;
  localparam logic [7:0] CMD_OC_RESP   = 8'h47;
  localparam logic [7:0] CMD_UTEMP_LIM  = 8'h53;
  localparam logic [7:0] CMD_UTEMP_RESP = 8'h54;
  localparam logic [7:0] CMD_VIN       = 8'h88;
  localparam logic [7:0] CMD_POUT      = 8'h96;
  localparam logic [7:0] CMD_FRAME_FW  = 8'hC4;
  localparam logic [7:0] CMD_MOD_FW    = 8'hC5;
  localparam logic [7:0] CMD_SERIAL    = 8'hC6;
  // response shapes
  localparam logic [4:0] STR_LEN       = 5'h0F;
  localparam logic [7:0] BLK_COUNT     = 8'h0F;
  localparam logic [7:0] PAD_CHAR      = 8'h20;
  localparam logic [7:0] NO_DATA       = 8'hFF;
  localparam logic [4:0] LAST_WORD     = 5'h02;
  localparam logic [4:0] LAST_BYTE     = 5'h01;
  localparam logic [4:0] LAST_BLK      = 5'h10;
  localparam logic [4:0] IDX_HI        = 5'h01;
  // receive byte positions: write address, command, read address
  localparam logic [1:0] RX_CMD_IDX    = 2'h1;
  localparam logic [1:0] RX_RD_IDX     = 2'h2;
  // status bit positions
  localparam int         SB_NOTA_BIT   = 0;
  localparam int         SW_VOUT_BIT   = 15;
  localparam int         SV_UVW_BIT    = 5;
  // crc-8 polynomial x^8+x^2+x+1, zero seed
  localparam logic [7:0] CRC_POLY      = 8'h07;
  localparam logic [7:0] CRC_INIT      = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_SEND = 3'b100
  } prr_state_t;
endpackage

/* hw/prr_crc_if.sv */
// link between the responder and its pec generator
`timescale 1ns/1ps
interface prr_crc_if;
  logic       clr;
  logic       en;
  logic [7:0] din;
  logic [7:0] crc;
  modport user (output clr, output en, output din, input crc);
  modport gen  (input clr, input en, input din, output crc);
endinterface

/* hw/prr_crc8.sv */
// smbus packet error code accumulator
`timescale 1ns/1ps
module prr_crc8
  import prr_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // byte stream
  prr_crc_if.gen    cif
);
  typedef struct packed {
    logic [7:0] crc;
  } prr_crc_regs_t;

  prr_crc_regs_t r_r;
  prr_crc_regs_t r_nxt;

  function automatic logic [7:0] prr_crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = c ^ d;
    for (int i = 0; i < 8; i++) begin
      v = v[7] ? ((v << 1) ^ CRC_POLY) : (v << 1);
    end
    return v;
  endfunction

  always_comb begin
    r_nxt = r_r;
    if (cif.clr) begin
      r_nxt.crc = CRC_INIT;
    end else if (cif.en) begin
      r_nxt.crc = prr_crc_step(r_r.crc, cif.din);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign cif.crc = r_r.crc;
endmodule

/* hw/prr_responder.sv */
// pmbus read responder for supply limits, telemetry and id strings
// Functional notes
// - uv warning sets status flags and alert
// - uv warn limit read returns two bytes
// - words go low byte first, tenths
// - uv warn limit always from page 0
// - oc fault limit read returns two bytes
// - other per-module values follow selected page/phase
// - oc response single byte, bits 7:6 mode
// - under-temperature limit signed tenths, low first
// - under-temperature response byte, same mode encoding
// - input voltage is product-wide, page independent
// - output power is total, page independent
// - frame firmware: count plus fifteen ascii
// - strings reversed, padded with spaces
// - module firmware: count, string, pec
// - serial number: count plus fifteen ascii
`timescale 1ns/1ps
module prr_responder
  import prr_pkg::*;
#(
  parameter int NPAGE = 2,
  parameter int SW    = (NPAGE > 1) ? $clog2(NPAGE) : 1
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  // byte link from the smbus bit engine
  input  wire logic                          frame_start,
  input  wire logic                          frame_stop,
  input  wire logic                          rx_valid,
  input  wire logic [7:0]                    rx_byte,
  input  wire logic                          tx_req,
  output logic                               tx_valid,
  output logic [7:0]                         tx_byte,
  // page or phase currently selected
  input  wire logic [SW-1:0]                 page_sel,
  // reported values: limits and telemetry in tenths of a unit, plus the two response bytes
  input  wire logic [NPAGE-1:0][15:0]        uv_warn_lim,
  input  wire logic [NPAGE-1:0][15:0]        oc_fault_lim,
  input  wire logic [NPAGE-1:0][15:0]        under_temperature_protection_lim,
  input  wire logic [7:0]                    oc_fault_resp,
  input  wire logic [7:0]                    under_temperature_protection_resp,
  input  wire logic [15:0]                   vin_meas,
  input  wire logic [15:0]                   pout_total,
  // id strings, character 0 first, with used length
  input  wire logic [14:0][7:0]              frame_fw_str,
  input  wire logic [3:0]                    frame_fw_len,
  input  wire logic [NPAGE-1:0][14:0][7:0]   mod_fw_str,
  input  wire logic [NPAGE-1:0][3:0]         mod_fw_len,
  input  wire logic [NPAGE-1:0][14:0][7:0]   serial_str,
  input  wire logic [NPAGE-1:0][3:0]         serial_len,
  // output voltage monitor, fault clear and alert enable
  input  wire logic                          vout_valid,
  input  wire logic [15:0]                   vout_meas,
  input  wire logic                          clear_faults,
  input  wire logic                          alert_en,
  // status and alert
  output logic [7:0]                         status_byte,
  output logic [15:0]                        status_word,
  output logic [7:0]                         status_vout,
  output logic                               host_alert_line_o,
  output logic                               host_alert_line_oe_n
);
  typedef struct packed {
    prr_state_t  st;
    logic [1:0]  rx_cnt;
    logic [4:0]  cnt;
    logic [7:0]  cmd;
    logic [SW-1:0] sel;
    logic [7:0]  tx_byte;
    logic        tx_valid;
    logic        uv_flag;
    logic        alert;
  } prr_regs_t;

  prr_regs_t   r_r;
  prr_regs_t   r_nxt;
  logic [15:0] word_val;
  logic        is_word;
  logic        is_byte;
  logic        is_blk;
  logic [4:0]  last_idx;
  logic [14:0][7:0] str_sel;
  logic [3:0]  len_sel;
  logic [3:0]  pos;
  logic [7:0]  resp_byte;

  prr_crc_if cif ();

  prr_crc8 u_crc (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cif     (cif.gen)
  );

  // response source selection
  always_comb begin
    word_val = '0;
    is_word  = 1'b1;
    is_byte  = 1'b0;
    is_blk   = 1'b0;
    str_sel  = frame_fw_str;
    len_sel  = frame_fw_len;
    case (r_r.cmd)
      CMD_UV_WARN:   word_val = uv_warn_lim[0];
      CMD_OC_LIM:    word_val = oc_fault_lim[r_r.sel];
      CMD_UTEMP_LIM: word_val = under_temperature_protection_lim[r_r.sel];
      CMD_VIN:       word_val = vin_meas;
      CMD_POUT:      word_val = pout_total;
      CMD_OC_RESP, CMD_UTEMP_RESP: begin
        is_word = 1'b0;
        is_byte = 1'b1;
      end
      CMD_FRAME_FW: begin
        is_word = 1'b0;
        is_blk  = 1'b1;
      end
      CMD_MOD_FW: begin
        is_word = 1'b0;
        is_blk  = 1'b1;
        str_sel = mod_fw_str[r_r.sel];
        len_sel = mod_fw_len[r_r.sel];
      end
      CMD_SERIAL: begin
        is_word = 1'b0;
        is_blk  = 1'b1;
        str_sel = serial_str[r_r.sel];
        len_sel = serial_len[r_r.sel];
      end
      default: is_word = 1'b0;
    endcase
  end

  // byte to send at the current index
  always_comb begin
    pos       = 4'(STR_LEN - r_r.cnt);
    last_idx  = is_word ? LAST_WORD : (is_byte ? LAST_BYTE : (is_blk ? LAST_BLK : '0));
    resp_byte = NO_DATA;
    if ((is_word || is_byte || is_blk) && r_r.cnt == last_idx) begin
      resp_byte = cif.crc;
    end else if (is_word) begin
      resp_byte = (r_r.cnt == IDX_HI) ? word_val[15:8] : word_val[7:0];
    end else if (is_byte) begin
      resp_byte = (r_r.cmd == CMD_OC_RESP) ? oc_fault_resp : under_temperature_protection_resp;
    end else if (is_blk) begin
      if (r_r.cnt == '0) begin
        resp_byte = BLK_COUNT;
      end else if (pos < len_sel) begin
        resp_byte = str_sel[pos];
      end else begin
        resp_byte = PAD_CHAR;
      end
    end
  end

  always_comb begin
    r_nxt          = r_r;
    r_nxt.tx_valid = 1'b0;
    cif.clr        = 1'b0;
    cif.en         = 1'b0;
    cif.din        = rx_byte;
    case (r_r.st)
      ST_IDLE: ;
      ST_CMD: begin
        if (rx_valid) begin
          cif.en       = 1'b1;
          r_nxt.rx_cnt = r_r.rx_cnt + 2'h1;
          if (r_r.rx_cnt == RX_CMD_IDX) begin
            r_nxt.cmd = rx_byte;
            r_nxt.sel = page_sel;
          end
          if (r_r.rx_cnt == RX_RD_IDX) begin
            r_nxt.st  = ST_SEND;
            r_nxt.cnt = '0;
          end
        end
      end
      ST_SEND: begin
        if (tx_req) begin
          cif.en         = 1'b1;
          cif.din        = resp_byte;
          r_nxt.tx_byte  = resp_byte;
          r_nxt.tx_valid = 1'b1;
          if (r_r.cnt != LAST_BLK) begin
            r_nxt.cnt = r_r.cnt + 5'h01;
          end
        end
      end
      default: r_nxt.st = ST_IDLE;
    endcase
    if (frame_stop) begin
      r_nxt.st = ST_IDLE;
    end
    if (frame_start) begin
      r_nxt.st     = ST_CMD;
      r_nxt.rx_cnt = '0;
      cif.clr      = 1'b1;
    end
    // the warning set wins over a clear in the same cycle
    if (clear_faults) begin
      r_nxt.uv_flag = 1'b0;
    end
    if (vout_valid && vout_meas < uv_warn_lim[0]) begin
      r_nxt.uv_flag = 1'b1;
    end
    r_nxt.alert = r_r.uv_flag && alert_en;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_r    <= '0;
      r_r.st <= ST_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tx_valid             = r_r.tx_valid;
  assign tx_byte              = r_r.tx_byte;
  assign status_byte          = 8'(r_r.uv_flag) << SB_NOTA_BIT;
  assign status_word          = 16'(r_r.uv_flag) << SW_VOUT_BIT;
  assign status_vout          = 8'(r_r.uv_flag) << SV_UVW_BIT;
  assign host_alert_line_o    = 1'b0;
  assign host_alert_line_oe_n = ~r_r.alert;

  logic sending;
  assign sending = (r_r.st == ST_SEND) && tx_req;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  uv_flag_set_a: assert property (
    vout_valid && vout_meas < uv_warn_lim[0] |=> status_vout[SV_UVW_BIT]
      && status_word[SW_VOUT_BIT] && status_byte[SB_NOTA_BIT])
    else $error("uv warning did not raise status flags");
  alert_drive_a: assert property (
    status_vout[SV_UVW_BIT] && alert_en |=> !host_alert_line_oe_n)
    else $error("alert line not driven on uv warning");
  uv_page0_a: assert property (
    sending && r_r.cmd == CMD_UV_WARN && r_r.cnt == '0
      |=> tx_valid && tx_byte == $past(uv_warn_lim[0][7:0]))
    else $error("uv limit low byte not from page 0");
  word_hi_a: assert property (
    sending && r_r.cmd == CMD_VIN && r_r.cnt == IDX_HI |=> tx_byte == $past(vin_meas[15:8]))
    else $error("word high byte wrong or misplaced");
  oc_page_a: assert property (
    sending && r_r.cmd == CMD_OC_LIM && r_r.cnt == '0
      |=> tx_byte == $past(oc_fault_lim[r_r.sel][7:0]))
    else $error("oc limit not from selected page");
  resp_byte_a: assert property (
    sending && r_r.cmd == CMD_OC_RESP && r_r.cnt == '0 |=> tx_byte == $past(oc_fault_resp))
    else $error("oc response byte wrong");
  blk_count_a: assert property (
    sending && is_blk && r_r.cnt == '0 |=> tx_byte == BLK_COUNT)
    else $error("block count byte wrong");
  pad_space_a: assert property (
    sending && is_blk && r_r.cnt != '0 && r_r.cnt != LAST_BLK && pos >= len_sel
      |=> tx_byte == PAD_CHAR)
    else $error("string padding not a space");
  pec_last_a: assert property (
    sending && (is_word || is_byte || is_blk) && r_r.cnt == last_idx
      |=> tx_valid && tx_byte == $past(cif.crc))
    else $error("pec byte wrong");

  word_read_c:  cover property (sending && is_word && r_r.cnt == LAST_WORD);
  block_read_c: cover property (sending && is_blk && r_r.cnt == LAST_BLK);
  alert_c:      cover property (!host_alert_line_oe_n);
endmodule

/* tb/prr_host_model.sv */
// behavioural pmbus host on the responder's byte link
`timescale 1ns/1ps
module prr_host_model (
  // clock
  input  wire logic       ref_clk,
  // byte link
  output logic            frame_start,
  output logic            frame_stop,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_req,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  logic [7:0] got [0:19];
  initial begin
    frame_start = 0;
    frame_stop  = 0;
    rx_valid    = 0;
    rx_byte     = 8'h5a;
    tx_req      = 0;
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  // address for write, command, address for read in one frame with no restart, then n reads and a stop
  task automatic read(input logic [7:0] cmd, input int n);
    logic [7:0] hdr [3];
    hdr = '{8'h10, cmd, 8'h11};
    step();
    frame_start = 1;
    step();
    frame_start = 0;
    rx_valid = 1;
    foreach (hdr[i]) begin
      rx_byte = hdr[i];
      step();
    end
    rx_valid = 0;
    // released data shows a changed value, not the last byte
    rx_byte = ~rx_byte;
    tx_req = 1;
    for (int k = 0; k < n; k++) begin
      step();
      got[k] = tx_valid ? tx_byte : 8'hxx;
      if (k == n - 1) tx_req = 0;
    end
    frame_stop = 1;
    step();
    frame_stop = 0;
  endtask
endmodule

/* tb/test_psu_pmbus_report_responder.sv */
// self-checking bench for the pmbus report responder
`timescale 1ns/1ps
module test_psu_pmbus_report_responder;
  import prr_pkg::*;
  logic                 ref_clk = 0;
  logic                 sys_rst = 1;
  logic                 frame_start, frame_stop, rx_valid, tx_req, tx_valid;
  logic                 vout_valid, clear_faults, alert_en;
  logic                 host_alert_line_o, host_alert_line_oe_n;
  logic [7:0]           rx_byte, tx_byte, oc_fault_resp, under_temperature_protection_resp;
  logic [7:0]           status_byte, status_vout;
  logic [15:0]          vin_meas, pout_total, vout_meas, status_word;
  logic [0:0]           page_sel;
  logic [1:0][15:0]     uv_warn_lim, oc_fault_lim, under_temperature_protection_lim;
  logic [14:0][7:0]     frame_fw_str;
  logic [3:0]           frame_fw_len;
  logic [1:0][14:0][7:0] mod_fw_str, serial_str;
  logic [1:0][3:0]      mod_fw_len, serial_len;
  logic [7:0]           e [$];
  int                   n_errors = 0;
  int                   num_checks = 0;

  always #5 ref_clk = ~ref_clk;

  prr_host_model i_host (.ref_clk, .frame_start, .frame_stop, .rx_valid, .rx_byte,
                         .tx_req, .tx_valid, .tx_byte);
  prr_responder #(.NPAGE(2)) i_dut (.ref_clk, .sys_rst, .frame_start, .frame_stop,
    .rx_valid, .rx_byte, .tx_req, .tx_valid, .tx_byte, .page_sel, .uv_warn_lim,
    .oc_fault_lim, .under_temperature_protection_lim, .oc_fault_resp,
    .under_temperature_protection_resp, .vin_meas,
    .pout_total, .frame_fw_str, .frame_fw_len, .mod_fw_str, .mod_fw_len, .serial_str,
    .serial_len, .vout_valid, .vout_meas, .clear_faults, .alert_en, .status_byte,
    .status_word, .status_vout, .host_alert_line_o, .host_alert_line_oe_n);

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction
  // reads e.size() bytes plus optional pec and compares all of them
  task automatic txn(logic [7:0] cmd, bit pec);
    logic [7:0] c;
    c = crc8(crc8(crc8(8'h00, 8'h10), cmd), 8'h11);
    i_host.read(cmd, e.size() + pec);
    foreach (e[k]) begin
      chk("data byte", i_host.got[k], e[k]);
      c = crc8(c, e[k]);
    end
    if (pec) chk("pec", i_host.got[e.size()], c);
  endtask
  task automatic word(logic [7:0] cmd, logic [15:0] v);
    e = {v[7:0], v[15:8]};
    txn(cmd, 1);
  endtask
  task automatic blk(logic [7:0] cmd, logic [14:0][7:0] s, logic [3:0] len);
    e = {BLK_COUNT};
    for (int k = 1; k <= 15; k++) e.push_back((15 - k) >= len ? 8'h20 : s[15 - k]);
    txn(cmd, 1);
  endtask
  function automatic logic [14:0][7:0] mk(string s);
    mk = {15{8'h7e}};
    for (int i = 0; i < s.len(); i++) mk[i] = s[i];
  endfunction

  task automatic t_words();
    for (int p = 0; p < 2; p++) begin
      page_sel = p[0:0];
      word(CMD_UV_WARN, 16'h0096);
      chk("uv pec", i_host.got[2], 8'hc5);
      word(CMD_OC_LIM, oc_fault_lim[p]);
      word(CMD_UTEMP_LIM, under_temperature_protection_lim[p]);
      word(CMD_VIN, 16'h0898);
      chk("vin pec", i_host.got[2], 8'h0b);
      word(CMD_POUT, pout_total);
    end
    e = {8'hff, 8'hff};
    txn(8'h42, 0);
  endtask
  task automatic t_bytes();
    page_sel = 1'b1;
    for (int m = 2; m < 4; m++) begin
      oc_fault_resp = {m[1:0], 6'h15};
      under_temperature_protection_resp = {m[1:0] ^ 2'b01, 6'h2a};
      e = {oc_fault_resp};
      txn(CMD_OC_RESP, 1);
      e = {under_temperature_protection_resp};
      txn(CMD_UTEMP_RESP, 1);
    end
  endtask
  task automatic t_strings();
    for (int p = 0; p < 2; p++) begin
      page_sel = p[0:0];
      blk(CMD_FRAME_FW, frame_fw_str, 4'h6);
      chk("frame pec", i_host.got[16], 8'h17);
      blk(CMD_MOD_FW, mod_fw_str[p], mod_fw_len[p]);
      blk(CMD_SERIAL, serial_str[p], serial_len[p]);
    end
  endtask
  task automatic t_uv();
    vout_valid = 1;
    vout_meas = 16'h0096;
    i_host.step();
    chk("no flag at limit", status_vout, 8'h00);
    vout_meas = 16'h0095;
    i_host.step();
    vout_valid = 0;
    chk("status byte", status_byte, 8'h01);
    chk("status word", status_word, 16'h8000);
    chk("status vout", status_vout, 8'h20);
    chk("alert early", host_alert_line_oe_n, 1'b1);
    i_host.step();
    chk("alert on", host_alert_line_oe_n, 1'b0);
    chk("alert level", host_alert_line_o, 1'b0);
    repeat (5) i_host.step();
    chk("sticky", status_byte, 8'h01);
    clear_faults = 1;
    i_host.step();
    clear_faults = 0;
    chk("cleared", status_word, 16'h0000);
    i_host.step();
    chk("alert off", host_alert_line_oe_n, 1'b1);
    alert_en = 0;
    vout_valid = 1;
    i_host.step();
    vout_valid = 0;
    repeat (2) i_host.step();
    chk("alert masked", host_alert_line_oe_n, 1'b1);
    chk("flag kept", status_vout, 8'h20);
    // a clear landing with a new warning must leave the flag set
    clear_faults = 1;
    vout_valid = 1;
    i_host.step();
    clear_faults = 0;
    vout_valid = 0;
    chk("set beats clear", status_vout, 8'h20);
    // reset in mid-run drops the flags, then a read works again
    sys_rst = 1;
    repeat (2) i_host.step();
    sys_rst = 0;
    chk("reset flags", status_byte, 8'h00);
    chk("reset alert", host_alert_line_oe_n, 1'b1);
    word(CMD_VIN, 16'h0898);
    chk("vin pec after reset", i_host.got[2], 8'h0b);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #60us;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    page_sel = 1'b0;
    uv_warn_lim = {16'h0123, 16'h0096};
    oc_fault_lim = {16'h1770, 16'h05dc};
    under_temperature_protection_lim = {16'hff9c, 16'hffce};
    oc_fault_resp = 8'h80;
    under_temperature_protection_resp = 8'hc0;
    vin_meas = 16'h0898;
    pout_total = 16'h1a2b;
    frame_fw_str = mk("S00E00");
    frame_fw_len = 4'h6;
    mod_fw_str = {mk("ABCDEFGHIJKLMNO"), mk("V1")};
    mod_fw_len = {4'hf, 4'h2};
    serial_str = {mk("0123456789"), mk("Z")};
    serial_len = {4'ha, 4'h1};
    vout_valid = 0;
    vout_meas = 16'h0fff;
    clear_faults = 0;
    alert_en = 1;
    repeat (10) @(posedge ref_clk);
    #1;
    sys_rst = 0;
    chk("tx idle", tx_valid, 1'b0);
    chk("alert idle", host_alert_line_oe_n, 1'b1);
    t_words();
    t_bytes();
    t_strings();
    t_uv();
    tally_and_finish();
  end
endmodule
